// File: hdl/ptw_pkg.sv
/*
  Shared constants and types for the two-wire potentiometer register access
  block: slave address layout, selector fields, timing counts and states.
  Assumes nothing of its surroundings.
*/
package ptw_pkg;
  // ==========================================================================
  // Timing
  localparam int MCLK_KHZ = 20000;
  localparam int SCL_KHZ = 100;
  localparam int QUARTER_CYCLES = MCLK_KHZ / (SCL_KHZ * 4);
  localparam int NV_WRITE_CYCLES_DEF = 2000;
  // Sized for write cycle lengths up to 65536 link clocks; a longer setting would wrap.
  localparam int TIMER_W = 16;
  // ==========================================================================
  // Addressing and fields
  localparam logic [3:0] DEV_TYPE_ID = 4'hA; // Arbitrary value.
  localparam logic [2:0] ADDR_SELECTOR = 3'h7;
  localparam logic [2:0] ADDR_UNUSED_LO = 3'h4;
  localparam logic [7:0] SELECTOR_RESET = 8'h00;
  localparam logic [7:0] NV_INIT = 8'h00;
  localparam int SEL_NV_BIT = 0;
  localparam int SEL_ROW_LO = 1;
  localparam int SEL_ROW_HI = 2;
  localparam int NUM_CH = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] KIND_SLV = 2'h0;
  localparam logic [1:0] KIND_ADR = 2'h1;
  localparam logic [1:0] KIND_DAT = 2'h2;
  // ==========================================================================
  // Types
  typedef logic [7:0] ptw_byte_t;
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_RX = 3'h1, DS_ACK = 3'h3,
    DS_TX = 3'h2, DS_MACK = 3'h6, DS_BUSY = 3'h7
  } ptw_dev_state_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_START = 3'h1, HS_BYTE = 3'h3,
    HS_RBYTE = 3'h2, HS_STOP = 3'h6
  } ptw_host_state_t;
endpackage

// File: hdl/ptw_link_if.sv
/*
  Two-wire link between the bus master and the potentiometer device.
  Assumes both data drivers are open drain; the serial clock is driven
  by the master only.
*/
`timescale 1ns/1ps
interface ptw_link_if;
  logic scl;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic sda;
  // A low is seen whenever either party pulls the line; otherwise pulled up.
  assign sda = ((!sda_h_oe_n && !sda_h_o) || (!sda_d_oe_n && !sda_d_o)) ? 1'b0 : 1'b1;
  modport host (output scl, output sda_h_o, output sda_h_oe_n, input sda);
  modport device (input scl, input sda, output sda_d_o, output sda_d_oe_n);
endinterface

// File: hdl/ptw_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes d_i is asynchronous to clk_i; q_o changes once stages two and
  three agree.
*/
`timescale 1ns/1ps
module ptw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  logic [W-1:0] agree;
  logic [W-1:0] nxt_q;

  always_comb begin
    agree = s2_ff ~^ s3_ff;
    nxt_q = (q_ff & ~agree) | (s3_ff & agree);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      q_ff <= INIT;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;
endmodule

// File: hdl/ptw_device.sv
/*
  Two-wire slave of a quad potentiometer: selector, wiper counters,
  nonvolatile rows, page buffer and write cycle timer.
  Assumes the link clock is much faster than the serial clock; the serial
  pins and straps are sampled as asynchronous inputs.
  // Overview of operation
  // - Slave hardware bits match pins; protect high.
  // - Byte write updates row and all wipers.
  // - Page bytes ordered channel 0 to 3.
  // - Master sets nonvolatile select before paging.
  // - Up to four acked bytes, channel increments.
  // - Channel counter wraps three to zero.
  // - Extra bytes overwrite earlier page bytes.
  // - Stop starts the nonvolatile write cycle.
  // - Inputs ignored during the write cycle.
  // - Protect low at stop discards bytes.
  // - Page bytes load wipers; others recall.
  // - Read returns register; all wipers recall.
  // - Random read: three acked address bytes.
  // - Bytes continue while master acknowledges.
  // - First read byte uses channel and selector.
  // - Read increments channel, wrapping around.
  // - Power-up pointer is channel zero.
  // - Read form: one or three bytes.
  // - Selector at address seven, resets zero.
  // - Selector bits pick wiper or row.
  // - Channel comes from the address byte.
  // - No acknowledge during the write cycle.
*/
`timescale 1ns/1ps
module ptw_device #(
  parameter int NV_WRITE_CYCLES = ptw_pkg::NV_WRITE_CYCLES_DEF
) (
  // Link clock and reset
  input wire logic link_clk_i,
  input wire logic reset_i,
  // Serial link
  ptw_link_if.device link,
  // Straps
  input wire logic hw_addr_pin0_i,
  input wire logic hw_addr_pin1_i,
  input wire logic hw_addr_pin2_i,
  input wire logic wp_n_i,
  // User side
  output logic [31:0] wiper_o,
  output ptw_pkg::ptw_byte_t selector_o,
  output logic busy_o
);
  import ptw_pkg::*;

  // ==========================================================================
  // Input sampling
  logic scl, sda, wp_ok;
  logic [2:0] pins;
  ptw_sync #(.W(2), .INIT(2'h3)) u_line_sync (
    .clk_i(link_clk_i),
    .reset_i(reset_i),
    .d_i({link.scl, link.sda}),
    .q_o({scl, sda})
  );
  ptw_sync #(.W(4), .INIT(4'h0)) u_strap_sync (
    .clk_i(link_clk_i),
    .reset_i(reset_i),
    .d_i({hw_addr_pin2_i, hw_addr_pin1_i, hw_addr_pin0_i, wp_n_i}),
    .q_o({pins, wp_ok})
  );

  // ==========================================================================
  // State
  ptw_dev_state_t state_ff, nxt_state;
  logic scl_p_ff, sda_p_ff;
  logic [1:0] kind_ff, nxt_kind;
  logic rw_ff, nxt_rw;
  logic tgt_sr_ff, nxt_tgt_sr;
  logic [1:0] ch_ff, nxt_ch;
  logic [3:0] cnt_ff, nxt_cnt;
  ptw_byte_t shift_ff, nxt_shift;
  logic sda_low_ff, nxt_sda_low;
  logic [TIMER_W-1:0] timer_ff, nxt_timer;
  ptw_byte_t sr_ff, nxt_sr;
  ptw_byte_t wcr_ff [NUM_CH];
  ptw_byte_t nxt_wcr [NUM_CH];
  ptw_byte_t nv_ff [NUM_CH*NUM_CH];
  ptw_byte_t nxt_nv [NUM_CH*NUM_CH];
  ptw_byte_t pbuf_ff [NUM_CH];
  ptw_byte_t nxt_pbuf [NUM_CH];
  logic [NUM_CH-1:0] mask_ff, nxt_mask;

  logic start, stop, rise, fall, load;
  logic [1:0] row;

  always_comb begin
    rise = scl && !scl_p_ff;
    fall = !scl && scl_p_ff;
    start = scl && scl_p_ff && sda_p_ff && !sda;
    stop = scl && scl_p_ff && !sda_p_ff && sda;
    row = {sr_ff[SEL_ROW_HI], sr_ff[SEL_ROW_LO]};
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_rw = rw_ff;
    nxt_tgt_sr = tgt_sr_ff;
    nxt_ch = ch_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_sda_low = sda_low_ff;
    nxt_timer = timer_ff;
    nxt_sr = sr_ff;
    nxt_mask = mask_ff;
    nxt_wcr = wcr_ff;
    nxt_nv = nv_ff;
    nxt_pbuf = pbuf_ff;
    load = 1'b0;
    if (state_ff == DS_BUSY) begin
      // Start, stop and clock edges are all ignored until the timer ends.
      nxt_sda_low = 1'b0;
      if (timer_ff == '0) begin
        nxt_state = DS_IDLE;
      end else begin
        nxt_timer = timer_ff - 1'b1;
      end
    end else if (stop) begin
      nxt_sda_low = 1'b0;
      nxt_state = DS_IDLE;
      if (mask_ff != '0 && wp_ok) begin
        for (int j = 0; j < NUM_CH; j++) begin
          if (mask_ff[j]) begin
            nxt_nv[{row, 2'(j)}] = pbuf_ff[j];
          end
        end
        nxt_timer = TIMER_W'(NV_WRITE_CYCLES - 1);
        nxt_state = DS_BUSY;
      end
      nxt_mask = '0;
    end else if (start) begin
      nxt_state = DS_RX;
      nxt_kind = KIND_SLV;
      nxt_cnt = '0;
      nxt_sda_low = 1'b0;
    end else begin
      case (state_ff)
        DS_RX: begin
          if (rise) begin
            nxt_shift = {shift_ff[6:0], sda};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (fall && cnt_ff == BITS_PER_BYTE) begin
            nxt_state = DS_ACK;
            nxt_sda_low = 1'b1;
            case (kind_ff)
              KIND_SLV: begin
                if (shift_ff[7:1] == {DEV_TYPE_ID, pins}) begin
                  nxt_rw = shift_ff[0];
                  nxt_kind = KIND_ADR;
                end else begin
                  nxt_state = DS_IDLE;
                  nxt_sda_low = 1'b0;
                end
              end
              KIND_ADR: begin
                nxt_kind = KIND_DAT;
                nxt_tgt_sr = shift_ff[2:0] == ADDR_SELECTOR;
                nxt_ch = shift_ff[1:0];
                if (shift_ff[2:0] >= ADDR_UNUSED_LO && shift_ff[2:0] != ADDR_SELECTOR) begin
                  nxt_state = DS_IDLE;
                  nxt_sda_low = 1'b0;
                end
              end
              default: begin
                if (tgt_sr_ff) begin
                  nxt_sr = shift_ff;
                  if (shift_ff[SEL_NV_BIT]) begin
                    for (int j = 0; j < NUM_CH; j++) begin
                      nxt_wcr[j] = nv_ff[{shift_ff[SEL_ROW_HI:SEL_ROW_LO], 2'(j)}];
                    end
                  end
                end else begin
                  nxt_wcr[ch_ff] = shift_ff;
                  nxt_ch = ch_ff + 2'h1;
                  if (sr_ff[SEL_NV_BIT]) begin
                    nxt_pbuf[ch_ff] = shift_ff;
                    nxt_mask[ch_ff] = 1'b1;
                    for (int j = 0; j < NUM_CH; j++) begin
                      if (2'(j) != ch_ff && !mask_ff[j]) begin
                        nxt_wcr[j] = nv_ff[{row, 2'(j)}];
                      end
                    end
                  end
                end
              end
            endcase
          end
        end
        DS_ACK: begin
          if (fall) begin
            nxt_sda_low = 1'b0;
            nxt_cnt = '0;
            if (rw_ff) begin
              load = 1'b1;
            end else begin
              nxt_state = DS_RX;
            end
          end
        end
        DS_TX: begin
          if (rise) begin
            nxt_cnt = cnt_ff + 4'h1;
          end else if (fall) begin
            if (cnt_ff == BITS_PER_BYTE) begin
              nxt_sda_low = 1'b0;
              nxt_state = DS_MACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_low = !shift_ff[6];
            end
          end
        end
        DS_MACK: begin
          if (rise) begin
            nxt_shift = {shift_ff[6:0], sda};
          end else if (fall) begin
            nxt_cnt = '0;
            if (!shift_ff[0]) begin
              load = 1'b1;
            end else begin
              nxt_state = DS_IDLE;
            end
          end
        end
        default: begin
          nxt_state = DS_IDLE;
        end
      endcase
    end
    if (load) begin
      nxt_state = DS_TX;
      if (tgt_sr_ff) begin
        nxt_shift = sr_ff;
      end else if (sr_ff[SEL_NV_BIT]) begin
        nxt_shift = nv_ff[{row, ch_ff}];
        for (int j = 0; j < NUM_CH; j++) begin
          nxt_wcr[j] = nv_ff[{row, 2'(j)}];
        end
        nxt_ch = ch_ff + 2'h1;
      end else begin
        nxt_shift = wcr_ff[ch_ff];
        nxt_ch = ch_ff + 2'h1;
      end
      nxt_sda_low = !nxt_shift[7];
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (reset_i) begin
      state_ff <= DS_IDLE;
      scl_p_ff <= 1'b1;
      sda_p_ff <= 1'b1;
      kind_ff <= KIND_SLV;
      rw_ff <= 1'b0;
      tgt_sr_ff <= 1'b0;
      ch_ff <= '0;
      cnt_ff <= '0;
      shift_ff <= '0;
      sda_low_ff <= 1'b0;
      timer_ff <= '0;
      sr_ff <= SELECTOR_RESET;
      mask_ff <= '0;
      for (int j = 0; j < NUM_CH; j++) begin
        wcr_ff[j] <= NV_INIT;
        pbuf_ff[j] <= NV_INIT;
      end
      for (int j = 0; j < NUM_CH * NUM_CH; j++) begin
        nv_ff[j] <= NV_INIT;
      end
    end else begin
      state_ff <= nxt_state;
      scl_p_ff <= scl;
      sda_p_ff <= sda;
      kind_ff <= nxt_kind;
      rw_ff <= nxt_rw;
      tgt_sr_ff <= nxt_tgt_sr;
      ch_ff <= nxt_ch;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      sda_low_ff <= nxt_sda_low;
      timer_ff <= nxt_timer;
      sr_ff <= nxt_sr;
      mask_ff <= nxt_mask;
      wcr_ff <= nxt_wcr;
      pbuf_ff <= nxt_pbuf;
      nv_ff <= nxt_nv;
    end
  end

  // ==========================================================================
  // Outputs
  assign link.sda_d_o = 1'b0;
  assign link.sda_d_oe_n = !sda_low_ff;
  assign wiper_o = {wcr_ff[3], wcr_ff[2], wcr_ff[1], wcr_ff[0]};
  assign selector_o = sr_ff;
  assign busy_o = state_ff == DS_BUSY;
endmodule

// File: hdl/ptw_host.sv
/*
  Two-wire bus master for the potentiometer device: byte and page writes,
  random and current-address reads.
  Assumes one command at a time; the serial clock is divided from mclk_i.
*/
`timescale 1ns/1ps
module ptw_host (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Serial link
  ptw_link_if.host link,
  // Command port
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_read_i,
  input wire logic cmd_random_i,
  input wire logic [2:0] cmd_hw_addr_i,
  input wire ptw_pkg::ptw_byte_t cmd_addr_i,
  input wire logic [3:0] cmd_len_i,
  input wire logic [31:0] cmd_wdata_i,
  // Answers
  output ptw_pkg::ptw_byte_t rd_data_o,
  output logic rd_valid_o,
  output logic done_o,
  output logic nack_o
);
  import ptw_pkg::*;

  // ==========================================================================
  // Returned data line
  logic sda;
  ptw_sync #(.W(1), .INIT(1'h1)) u_sda_sync (
    .clk_i(mclk_i),
    .reset_i(reset_i),
    .d_i(link.sda),
    .q_o(sda)
  );

  // ==========================================================================
  // Sequencer
  ptw_host_state_t state_ff, nxt_state;
  logic [7:0] div_ff, nxt_div;
  logic [1:0] q_ff, nxt_q;
  logic [1:0] stage_ff, nxt_stage;
  logic [3:0] bit_ff, nxt_bit;
  logic [3:0] left_ff, nxt_left;
  logic [1:0] idx_ff, nxt_idx;
  ptw_byte_t shift_ff, nxt_shift;
  logic scl_ff, nxt_scl;
  logic oe_n_ff, nxt_oe_n;
  logic read_ff, nxt_read;
  logic random_ff, nxt_random;
  logic [2:0] hw_ff, nxt_hw;
  ptw_byte_t addr_ff, nxt_addr;
  logic [31:0] wdata_ff, nxt_wdata;
  ptw_byte_t rd_ff, nxt_rd;
  logic rdv_ff, nxt_rdv;
  logic done_ff, nxt_done;
  logic nack_ff, nxt_nack;
  logic tick;

  always_comb begin
    tick = div_ff == 8'(QUARTER_CYCLES - 1);
    nxt_div = tick ? 8'h00 : div_ff + 8'h01;
    nxt_state = state_ff;
    nxt_q = q_ff;
    nxt_stage = stage_ff;
    nxt_bit = bit_ff;
    nxt_left = left_ff;
    nxt_idx = idx_ff;
    nxt_shift = shift_ff;
    nxt_scl = scl_ff;
    nxt_oe_n = oe_n_ff;
    nxt_read = read_ff;
    nxt_random = random_ff;
    nxt_hw = hw_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rd = rd_ff;
    nxt_rdv = 1'b0;
    nxt_done = 1'b0;
    nxt_nack = nack_ff;
    if (state_ff == HS_IDLE) begin
      nxt_q = '0;
      if (cmd_valid_i) begin
        nxt_state = HS_START;
        nxt_stage = '0;
        nxt_idx = '0;
        nxt_read = cmd_read_i;
        nxt_random = cmd_random_i;
        nxt_hw = cmd_hw_addr_i;
        nxt_addr = cmd_addr_i;
        nxt_left = cmd_len_i;
        nxt_wdata = cmd_wdata_i;
        nxt_nack = 1'b0;
      end
    end else if (tick) begin
      nxt_q = q_ff + 2'h1;
      case (state_ff)
        HS_START: begin
          case (q_ff)
            2'h0: nxt_oe_n = 1'b1;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe_n = 1'b0;
            default: begin
              nxt_scl = 1'b0;
              nxt_state = HS_BYTE;
              nxt_bit = '0;
              nxt_shift = {DEV_TYPE_ID, hw_ff,
                           (stage_ff == 2'h2) || (read_ff && !random_ff)};
            end
          endcase
        end
        HS_BYTE: begin
          case (q_ff)
            2'h0: nxt_oe_n = (bit_ff == BITS_PER_BYTE) ? 1'b1 : shift_ff[7];
            2'h1: nxt_scl = 1'b1;
            2'h2: begin
              if (bit_ff == BITS_PER_BYTE) begin
                nxt_shift[0] = sda;
              end
            end
            default: begin
              nxt_scl = 1'b0;
              nxt_bit = bit_ff + 4'h1;
              if (bit_ff != BITS_PER_BYTE) begin
                nxt_shift = {shift_ff[6:0], 1'b0};
              end else if (shift_ff[0]) begin
                nxt_nack = 1'b1;
                nxt_state = HS_STOP;
              end else begin
                nxt_bit = '0;
                case (stage_ff)
                  2'h0: begin
                    if (read_ff && !random_ff) begin
                      nxt_state = HS_RBYTE;
                      nxt_stage = 2'h3;
                    end else begin
                      nxt_shift = addr_ff;
                      nxt_stage = 2'h1;
                    end
                  end
                  2'h1: begin
                    nxt_stage = read_ff ? 2'h2 : 2'h3;
                    nxt_state = read_ff ? HS_START : HS_BYTE;
                    nxt_shift = wdata_ff[{idx_ff, 3'h0} +: 8];
                  end
                  2'h2: begin
                    nxt_state = HS_RBYTE;
                    nxt_stage = 2'h3;
                  end
                  default: begin
                    nxt_idx = idx_ff + 2'h1;
                    nxt_left = left_ff - 4'h1;
                    nxt_shift = wdata_ff[{nxt_idx, 3'h0} +: 8];
                    if (left_ff <= 4'h1) begin
                      nxt_state = HS_STOP;
                    end
                  end
                endcase
              end
            end
          endcase
        end
        HS_RBYTE: begin
          case (q_ff)
            2'h0: begin
              nxt_oe_n = 1'b1;
              if (bit_ff == BITS_PER_BYTE) begin
                nxt_oe_n = left_ff <= 4'h1;
              end
            end
            2'h1: nxt_scl = 1'b1;
            2'h2: begin
              if (bit_ff != BITS_PER_BYTE) begin
                nxt_shift = {shift_ff[6:0], sda};
              end
            end
            default: begin
              nxt_scl = 1'b0;
              nxt_bit = bit_ff + 4'h1;
              if (bit_ff == BITS_PER_BYTE) begin
                nxt_bit = '0;
                nxt_rd = shift_ff;
                nxt_rdv = 1'b1;
                nxt_left = left_ff - 4'h1;
                if (left_ff <= 4'h1) begin
                  nxt_state = HS_STOP;
                end
              end
            end
          endcase
        end
        HS_STOP: begin
          case (q_ff)
            2'h0: nxt_oe_n = 1'b0;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe_n = 1'b1;
            default: begin
              nxt_done = 1'b1;
              nxt_state = HS_IDLE;
            end
          endcase
        end
        default: nxt_state = HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_ff <= HS_IDLE;
      div_ff <= '0;
      q_ff <= '0;
      stage_ff <= '0;
      bit_ff <= '0;
      left_ff <= '0;
      idx_ff <= '0;
      shift_ff <= '0;
      scl_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      read_ff <= 1'b0;
      random_ff <= 1'b0;
      hw_ff <= '0;
      addr_ff <= '0;
      wdata_ff <= '0;
      rd_ff <= '0;
      rdv_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      q_ff <= nxt_q;
      stage_ff <= nxt_stage;
      bit_ff <= nxt_bit;
      left_ff <= nxt_left;
      idx_ff <= nxt_idx;
      shift_ff <= nxt_shift;
      scl_ff <= nxt_scl;
      oe_n_ff <= nxt_oe_n;
      read_ff <= nxt_read;
      random_ff <= nxt_random;
      hw_ff <= nxt_hw;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rd_ff <= nxt_rd;
      rdv_ff <= nxt_rdv;
      done_ff <= nxt_done;
      nack_ff <= nxt_nack;
    end
  end

  assign link.scl = scl_ff;
  assign link.sda_h_o = 1'b0;
  assign link.sda_h_oe_n = oe_n_ff;
  assign cmd_ready_o = state_ff == HS_IDLE;
  assign rd_data_o = rd_ff;
  assign rd_valid_o = rdv_ff;
  assign done_o = done_ff;
  assign nack_o = nack_ff;
endmodule

// File: test/ptw_chk.sv
/*
  Checker for the two-wire potentiometer link: wire timing and the
  nonvolatile write cycle of the device end.
  Assumes the testbench instantiates it beside the link interface.
*/
`timescale 1ns/1ps
module ptw_chk #(
  parameter int NV_WRITE_CYCLES = 20
) (
  // Clocks and reset
  input wire logic mclk_i,
  input wire logic link_clk_i,
  input wire logic reset_i,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_oe_n,
  // Device straps and outputs
  input wire logic wp_n_i,
  input wire logic busy_o,
  input wire logic [31:0] wiper_o,
  input wire ptw_pkg::ptw_byte_t selector_o
);
  import ptw_pkg::*;
  // ==========================================================================
  // Busy length counter
  // The write cycle is far too long for a repetition, so it is counted here.
  int busy_cnt_ff;
  int nxt_busy_cnt;
  always_comb begin
    nxt_busy_cnt = busy_o ? busy_cnt_ff + 1 : 0;
  end
  always_ff @(posedge link_clk_i) begin
    busy_cnt_ff <= reset_i ? 0 : nxt_busy_cnt;
  end
  // ==========================================================================
  // Properties
  sequence s_bus_idle;
    scl && sda;
  endsequence
  sequence s_scl_rise;
    ##[1:1000] $rose(scl);
  endsequence
  property p_busy_release;
    @(posedge link_clk_i) disable iff (reset_i) busy_o |-> sda_d_oe_n;
  endproperty
  property p_busy_len;
    @(posedge link_clk_i) disable iff (reset_i)
      $fell(busy_o) |-> busy_cnt_ff == NV_WRITE_CYCLES;
  endproperty
  property p_busy_wp;
    @(posedge link_clk_i) disable iff (reset_i) $rose(busy_o) |-> wp_n_i;
  endproperty
  property p_busy_stop;
    @(posedge link_clk_i) disable iff (reset_i) $rose(busy_o) |-> s_bus_idle;
  endproperty
  property p_busy_frozen;
    @(posedge link_clk_i) disable iff (reset_i)
      busy_o && $past(busy_o) |-> $stable(wiper_o) && $stable(selector_o);
  endproperty
  property p_drive_scl_low;
    @(posedge link_clk_i) disable iff (reset_i) $changed(sda_d_oe_n) |-> !scl;
  endproperty
  property p_bit_held;
    @(posedge link_clk_i) disable iff (reset_i)
      $fell(sda_d_oe_n) |-> !sda_d_oe_n throughout s_scl_rise;
  endproperty
  property p_scl_high;
    @(posedge mclk_i) disable iff (reset_i) $rose(scl) |=> scl [*8];
  endproperty
  a_busy_release: assert property (p_busy_release)
    else $error("device drove data while busy");
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");
  a_busy_wp: assert property (p_busy_wp)
    else $error("write cycle started with protect low");
  a_busy_stop: assert property (p_busy_stop)
    else $error("write cycle started without stop");
  a_busy_frozen: assert property (p_busy_frozen)
    else $error("registers changed while busy");
  a_drive_scl_low: assert property (p_drive_scl_low)
    else $error("device changed data while clock high");
  a_bit_held: assert property (p_bit_held)
    else $error("device bit not held over clock high");
  a_scl_high: assert property (p_scl_high)
    else $error("serial clock high phase too short");
endmodule

// File: test/testbench.sv
/*
  Testbench for the two-wire potentiometer link: host and device face each
  other through the link interface; command rows, then awkward cases.
  Assumes package, interface, design and checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import ptw_pkg::*;
  // ==========================================================================
  // Signals and command rows
  // Long enough that a command issued just after a commit meets a busy device.
  localparam int NVC = 20000;
  typedef struct {
    logic r, q;
    logic [7:0] a;
    logic [3:0] l;
    logic [31:0] d, w;
    logic [7:0] s, f, e;
    logic k;
  } ptw_tb_row_t;
  logic mclk_i = 1'h0;
  logic link_clk = 1'h0;
  logic reset_i = 1'h1;
  logic wp_n = 1'h1;
  logic [2:0] pins = 3'h3;
  logic [2:0] hw = 3'h3;
  logic valid = 1'h0;
  logic rd = 1'h0;
  logic rnd = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [3:0] len = 4'h1;
  logic [31:0] wd = 32'h0;
  logic ready, rvld, done, nack, busy;
  logic [7:0] rdata, sel, first;
  logic [31:0] wip;
  int error_cnt = 0;
  int cmp_count = 0;
  ptw_tb_row_t rows [8] = '{
    '{1'h0, 1'h0, 8'h07, 4'h1, 32'h03, 32'h00000000, 8'h03, 8'h00, 8'h00, 1'h0},
    '{1'h0, 1'h0, 8'h02, 4'h3, 32'h113322, 32'h33220011, 8'h03, 8'h00, 8'h00, 1'h0},
    '{1'h0, 1'h0, 8'h07, 4'h1, 32'h00, 32'h33220011, 8'h00, 8'h00, 8'h00, 1'h0},
    '{1'h0, 1'h0, 8'h01, 4'h1, 32'h5A, 32'h33225A11, 8'h00, 8'h00, 8'h00, 1'h0},
    '{1'h0, 1'h0, 8'h07, 4'h1, 32'h03, 32'h33220011, 8'h03, 8'h00, 8'h00, 1'h0},
    '{1'h1, 1'h1, 8'h02, 4'h2, 32'h00, 32'h33220011, 8'h03, 8'h22, 8'h33, 1'h0},
    '{1'h1, 1'h0, 8'h00, 4'h1, 32'h00, 32'h33220011, 8'h03, 8'h11, 8'h11, 1'h0},
    '{1'h0, 1'h0, 8'h05, 4'h1, 32'h77, 32'h33220011, 8'h03, 8'h00, 8'h00, 1'h1}
  };
  always #25 mclk_i = ~mclk_i;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  // ==========================================================================
  // Design, link and checker
  ptw_link_if link ();
  ptw_host i_ptw_host (.mclk_i(mclk_i), .reset_i(reset_i), .link(link.host),
    .cmd_valid_i(valid), .cmd_ready_o(ready), .cmd_read_i(rd), .cmd_random_i(rnd),
    .cmd_hw_addr_i(hw), .cmd_addr_i(addr), .cmd_len_i(len), .cmd_wdata_i(wd),
    .rd_data_o(rdata), .rd_valid_o(rvld), .done_o(done), .nack_o(nack));
  ptw_device #(.NV_WRITE_CYCLES(NVC)) i_ptw_device (.link_clk_i(link_clk),
    .reset_i(reset_i), .link(link.device), .hw_addr_pin0_i(pins[0]),
    .hw_addr_pin1_i(pins[1]), .hw_addr_pin2_i(pins[2]), .wp_n_i(wp_n),
    .wiper_o(wip), .selector_o(sel), .busy_o(busy));
  ptw_chk #(.NV_WRITE_CYCLES(NVC)) i_ptw_chk (.mclk_i(mclk_i), .link_clk_i(link_clk),
    .reset_i(reset_i), .scl(link.scl), .sda(link.sda), .sda_d_oe_n(link.sda_d_oe_n),
    .wp_n_i(wp_n), .busy_o(busy), .wiper_o(wip), .selector_o(sel));
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic run(input logic r, input logic q, input logic [7:0] a,
                     input logic [3:0] l, input logic [31:0] d, input logic w);
    int n;
    logic got;
    n = 0;
    got = 1'h0;
    @(posedge mclk_i);
    #1;
    valid = 1'h1;
    rd = r;
    rnd = q;
    addr = a;
    len = l;
    wd = d;
    @(posedge mclk_i);
    #1;
    valid = 1'h0;
    while (done !== 1'h1 && n < 30000) begin
      @(posedge mclk_i);
      #1;
      n++;
      if (rvld === 1'h1 && !got) begin
        first = rdata;
        got = 1'h1;
      end
    end
    repeat (4) @(posedge mclk_i);
    #1;
    while (w && busy === 1'h1 && n < 30000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= 30000) begin
      error_cnt++;
      stop_test();
    end
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    repeat (6) @(posedge mclk_i);
    #1;
    reset_i = 1'h0;
    chk(sel, 32'h0);
    chk(wip, 32'h0);
    chk(ready, 32'h1);
    for (int i = 0; i < 8; i++) begin
      run(rows[i].r, rows[i].q, rows[i].a, rows[i].l, rows[i].d, 1'h1);
      chk(wip, rows[i].w);
      chk(sel, rows[i].s);
      chk(nack, rows[i].k);
      if (rows[i].r) begin
        chk(first, rows[i].f);
        chk(rdata, rows[i].e);
      end
    end
    wp_n = 1'h0;
    run(1'h0, 1'h0, 8'h00, 4'h1, 32'h77, 1'h1);
    chk(wip, 32'h33220077);
    wp_n = 1'h1;
    run(1'h1, 1'h1, 8'h00, 4'h1, 32'h00, 1'h1);
    chk(first, 32'h11);
    chk(wip, 32'h33220011);
    run(1'h0, 1'h0, 8'h00, 4'h1, 32'h44, 1'h0);
    run(1'h0, 1'h0, 8'h07, 4'h1, 32'h05, 1'h1);
    chk(nack, 32'h1);
    chk(sel, 32'h03);
    chk(wip, 32'h33220044);
    hw = 3'h5;
    run(1'h0, 1'h0, 8'h07, 4'h1, 32'h05, 1'h1);
    chk(nack, 32'h1);
    chk(sel, 32'h03);
    stop_test();
  end
endmodule
